// file: hdl/ahpp_dec_if.sv
// Carrier between the port engine and its address decoder
`timescale 1ns/1ps
`default_nettype none
interface ahpp_dec_if;
   import ahpp_pkg::*;
   logic [AHPP_ADDR_W-1:0] addr;
   logic [AHPP_LANES-1:0] be_n;
   logic wide;
   logic is_write;
   logic is_sdram;
   logic [AHPP_WADDR_W-1:0] waddr;
   logic [AHPP_LANES-1:0] mask;
   logic legal;

   modport port (output addr, be_n, wide, is_write, input is_sdram, waddr, mask, legal);
   modport dec (input addr, be_n, wide, is_write, output is_sdram, waddr, mask, legal);
endinterface : ahpp_dec_if
`default_nettype wire

// file: hdl/ahpp_decode.sv
// Address and byte-lane decoder for the host parallel bus port
`timescale 1ns/1ps
`default_nettype none
module ahpp_decode (
   ahpp_dec_if.dec d
);
   import ahpp_pkg::*;

   logic [AHPP_LANES-1:0] sel;

   // Region split, word address and lane mask
   always_comb begin
      sel = ~d.be_n;
      d.is_sdram = (d.addr >= AHPP_SDRAM_BASE);
      d.waddr = d.addr[AHPP_ADDR_W-1:1];
      if (d.wide) begin
         // low enable marks lane, BE3 is byte 0
         d.mask = sel;
      end else if (!d.addr[0]) begin
         // even half-word sits in the upper lanes
         d.mask = {sel[1:0], 2'h0};
      end else begin
         d.mask = {2'h0, sel[1:0]};
      end
      // reads always cover the whole bus width
      if (!d.is_write) begin
         d.mask = d.wide ? AHPP_MASK_FULL : (d.addr[0] ? 4'h3 : 4'hC);
      end
      // legal widths per target and bus mode
      if (!d.is_write) begin
         d.legal = 1'b1;
      end else if (!d.is_sdram) begin
         d.legal = d.wide ? (sel == AHPP_MASK_FULL) : (sel[1:0] == 2'h3);
      end else if (d.wide) begin
         case (sel)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: d.legal = 1'b1;
            default: d.legal = 1'b0;
         endcase
      end else begin
         d.legal = (sel[1:0] != 2'h0);
      end
   end
endmodule : ahpp_decode
`default_nettype wire

// file: hdl/ahpp_pkg.sv
// Constants and types shared by the asynchronous host parallel bus port
// Functional notes
// - Parallel host mode chosen when mode strap is high at reset release.
// - Width strap 1 gives 32-bit bus, four enables; 0 gives 16-bit, two enables.
// - Registers only full width; SDRAM 8/16/32 bits wide, or 8/16 in narrow mode.
// - One data item per chip select; no bursts from either side.
// - Byte lanes map big-endian between host bus and internal word.
// - Ready asserted once write stored or read data valid on bus.
// - Host releases chip select after ready; device then removes ready.
// - Writes posted with immediate ready; next access waits for that write.
// - Wide mode: enables replace two low address bits; address bit 1 ignored.
// - Narrow mode: enables replace address bit 0; address bit 1 decoded.
// - SDRAM writes update only lanes whose enable is asserted.
// - Reads always full bus width; host holds enables high on reads.
// - Narrow mode SDRAM reads are always full 16 bits.
// - Each legal access classed register or SDRAM, forwarded, read data returned.
// - Whole port held in reset while system reset input is low.
`default_nettype none
package ahpp_pkg;
   localparam int AHPP_ADDR_W = 24;
   localparam int AHPP_WADDR_W = 23;
   localparam int AHPP_DATA_W = 32;
   localparam int AHPP_HALF_W = 16;
   localparam int AHPP_LANES = 4;
   // Host half-word address at and above which accesses go to SDRAM
   localparam logic [AHPP_ADDR_W-1:0] AHPP_SDRAM_BASE = 24'h800000;
   localparam logic [AHPP_LANES-1:0] AHPP_MASK_NONE = 4'h0;
   localparam logic [AHPP_LANES-1:0] AHPP_MASK_FULL = 4'hF;
   localparam logic [AHPP_DATA_W-1:0] AHPP_DATA_RST = 32'h00000000;
   localparam logic [AHPP_WADDR_W-1:0] AHPP_WADDR_RST = 23'h000000;
   localparam logic AHPP_STRAP_PARALLEL = 1'b1;
   localparam logic AHPP_STRAP_WIDE = 1'b1;

   typedef enum logic [1:0] {
      AHPP_IDLE,
      AHPP_READ,
      AHPP_DONE
   } ahpp_state_t;
endpackage : ahpp_pkg
`default_nettype wire

// file: hdl/ahpp_port.sv
// Host parallel bus port: strap capture, posted writes, target forwarding
`timescale 1ns/1ps
`default_nettype none
module ahpp_port (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic port_mode_strap,
   input wire logic width_strap,
   input wire logic host_cs_n,
   input wire logic host_r_w_n,
   input wire logic [ahpp_pkg::AHPP_ADDR_W:1] host_addr,
   input wire logic [ahpp_pkg::AHPP_LANES-1:0] host_byte_enable_n,
   input wire logic [ahpp_pkg::AHPP_DATA_W-1:0] host_data_in,
   output logic [ahpp_pkg::AHPP_DATA_W-1:0] host_data_out,
   output logic host_data_oe_n,
   output logic host_ready_n,
   output logic parallel_mode,
   output logic wide_mode,
   output logic reg_req,
   output logic sdram_req,
   output logic tgt_write,
   output logic [ahpp_pkg::AHPP_WADDR_W-1:0] tgt_waddr,
   output logic [ahpp_pkg::AHPP_LANES-1:0] tgt_mask,
   output logic [ahpp_pkg::AHPP_DATA_W-1:0] tgt_wdata,
   input wire logic tgt_ack,
   input wire logic [ahpp_pkg::AHPP_DATA_W-1:0] tgt_rdata
);
   import ahpp_pkg::*;

   typedef struct packed {
      ahpp_state_t state;
      logic strap_done;
      logic parallel;
      logic wide;
      logic half_lo;
      logic ready_n;
      logic oe_n;
      logic [AHPP_DATA_W-1:0] dout;
      logic reg_req;
      logic sdram_req;
      logic write;
      logic [AHPP_WADDR_W-1:0] waddr;
      logic [AHPP_LANES-1:0] mask;
      logic [AHPP_DATA_W-1:0] wdata;
   } ahpp_regs_t;

   localparam ahpp_regs_t AHPP_REGS_RST = '{
      state: AHPP_IDLE,
      strap_done: 1'b0,
      parallel: 1'b0,
      wide: 1'b0,
      half_lo: 1'b0,
      ready_n: 1'b1,
      oe_n: 1'b1,
      dout: AHPP_DATA_RST,
      reg_req: 1'b0,
      sdram_req: 1'b0,
      write: 1'b0,
      waddr: AHPP_WADDR_RST,
      mask: AHPP_MASK_NONE,
      wdata: AHPP_DATA_RST
   };

   ahpp_regs_t r_q;
   ahpp_regs_t r_d;
   logic busy;
   logic start;

   ahpp_dec_if dec_bus ();

   ahpp_decode u_decode (
      .d(dec_bus)
   );

   // Present the live host request to the decoder
   assign dec_bus.addr = host_addr;
   assign dec_bus.be_n = host_byte_enable_n;
   assign dec_bus.wide = r_q.wide;
   assign dec_bus.is_write = !host_r_w_n;

   // A target request outstanding means a posted write or a read is in flight
   assign busy = r_q.reg_req | r_q.sdram_req;
   // a fresh access only from idle, one per chip select
   assign start = r_q.strap_done && r_q.parallel && !host_cs_n && (r_q.state == AHPP_IDLE);

   // Next-state logic for the whole port
   always_comb begin
      r_d = r_q;
      // straps caught on the first clock-enabled edge after reset release
      if (!r_q.strap_done) begin
         r_d.strap_done = 1'b1;
         r_d.parallel = (port_mode_strap == AHPP_STRAP_PARALLEL);
         r_d.wide = (width_strap == AHPP_STRAP_WIDE);
      end
      // Target handshake retires the outstanding request
      if (busy && tgt_ack) begin
         r_d.reg_req = 1'b0;
         r_d.sdram_req = 1'b0;
      end
      case (r_q.state)
         AHPP_IDLE: begin
            // next access held off until the posted write completes
            if (start && !busy) begin
               r_d.write = !host_r_w_n;
               r_d.waddr = dec_bus.waddr;
               r_d.mask = dec_bus.mask;
               r_d.half_lo = host_addr[1];
               // narrow data copied into both halves, mask picks one
               r_d.wdata = r_q.wide ? host_data_in :
                  {host_data_in[AHPP_HALF_W-1:0], host_data_in[AHPP_HALF_W-1:0]};
               // forward to register or SDRAM target
               if (dec_bus.legal) begin
                  r_d.reg_req = !dec_bus.is_sdram;
                  r_d.sdram_req = dec_bus.is_sdram;
               end
               if (!host_r_w_n) begin
                  r_d.ready_n = 1'b0;
                  r_d.state = AHPP_DONE;
               end else begin
                  r_d.state = AHPP_READ;
               end
            end
         end
         AHPP_READ: begin
            if (tgt_ack) begin
               // full width read placed on the bus
               if (r_q.wide) begin
                  r_d.dout = tgt_rdata;
               end else begin
                  r_d.dout = {16'h0000, r_q.half_lo ? tgt_rdata[AHPP_HALF_W-1:0] :
                     tgt_rdata[AHPP_DATA_W-1:AHPP_HALF_W]};
               end
               r_d.oe_n = 1'b0;
               r_d.ready_n = 1'b0;
               r_d.state = AHPP_DONE;
            end
         end
         AHPP_DONE: begin
            // chip select release closes the access
            if (host_cs_n) begin
               r_d.ready_n = 1'b1;
               r_d.oe_n = 1'b1;
               r_d.state = AHPP_IDLE;
            end
         end
         default: begin
            r_d = AHPP_REGS_RST;
         end
      endcase
   end

   // State register with clock enable
   always_ff @(posedge sys_clk) begin
      // held in reset while the system reset is low
      if (!rst_b) begin
         r_q <= AHPP_REGS_RST;
      end else if (clk_en) begin
         r_q <= r_d;
      end
   end

   // Outputs come straight from the state register
   assign host_data_out = r_q.dout;
   assign host_data_oe_n = r_q.oe_n;
   assign host_ready_n = r_q.ready_n;
   assign parallel_mode = r_q.parallel;
   assign wide_mode = r_q.wide;
   assign reg_req = r_q.reg_req;
   assign sdram_req = r_q.sdram_req;
   assign tgt_write = r_q.write;
   assign tgt_waddr = r_q.waddr;
   // only enabled lanes written in SDRAM
   assign tgt_mask = r_q.mask;
   assign tgt_wdata = r_q.wdata;
endmodule : ahpp_port
`default_nettype wire

// file: tb/ahpp_port_assertions.sv
// Handshake checks for the host parallel bus port
`timescale 1ns/1ps
`default_nettype none
module ahpp_port_chk (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic host_cs_n,
   input wire logic host_r_w_n,
   input wire logic [24:1] host_addr,
   input wire logic host_ready_n,
   input wire logic host_data_oe_n,
   input wire logic parallel_mode,
   input wire logic reg_req,
   input wire logic sdram_req,
   input wire logic tgt_ack
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Any target request pending
   wire logic busy = reg_req | sdram_req;
   sequence s_wr_take; $fell(host_cs_n) && !host_r_w_n && parallel_mode && !busy; endsequence
   property p_post; s_wr_take |=> !host_ready_n; endproperty
   a_post: assert property (p_post) else $error("write ready late");
   property p_wait; $fell(host_ready_n) && !host_r_w_n |-> !$past(busy); endproperty
   a_wait: assert property (p_wait) else $error("ready while busy");
   property p_rd; $fell(host_ready_n) && host_r_w_n |-> $past(tgt_ack); endproperty
   a_rd: assert property (p_rd) else $error("read ready early");
   property p_oe; !host_data_oe_n |-> !host_ready_n && host_r_w_n; endproperty
   a_oe: assert property (p_oe) else $error("drive outside read");
   property p_rel; !host_ready_n && host_cs_n |=> host_ready_n && host_data_oe_n; endproperty
   a_rel: assert property (p_rel) else $error("ready kept");
   property p_one; !(reg_req && sdram_req); endproperty
   a_one: assert property (p_one) else $error("two targets");
   property p_ack; busy && tgt_ack |=> !busy; endproperty
   a_ack: assert property (p_ack) else $error("request kept");
   property p_map; $rose(sdram_req) |-> host_addr[24]; endproperty
   a_map: assert property (p_map) else $error("wrong region");
   property p_off; !parallel_mode |-> host_ready_n; endproperty
   a_off: assert property (p_off) else $error("ready when off");
endmodule : ahpp_port_chk
bind ahpp_port ahpp_port_chk chk_u (.*);
`default_nettype wire

// file: tb/ahpp_port_tb.sv
// Self-checking bench for the host parallel bus port
`timescale 1ns/1ps
`default_nettype none
module ahpp_port_tb;
   logic sys_clk = 1'h0, rst_b = 1'h0, pm = 1'h1, wd = 1'h1, cs_n = 1'h1, rw_n = 1'h1;
   logic ce = 1'h1;
   logic rdy_n, oe_n, pmo, wmo, rr, sr, tw, ack;
   logic [24:1] ad = 24'h0;
   logic [3:0] be = 4'hF, mk, dly = 4'h0;
   logic [22:0] wa;
   logic [31:0] din = 32'h0, dout, wdo, rd, q;
   int mismatches = 0, checks_done = 0, cyc = 0;
   initial forever #25 sys_clk = ~sys_clk;
   ahpp_port dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce), .port_mode_strap(pm),
      .width_strap(wd), .host_cs_n(cs_n), .host_r_w_n(rw_n), .host_addr(ad),
      .host_byte_enable_n(be), .host_data_in(din), .host_data_out(dout),
      .host_data_oe_n(oe_n), .host_ready_n(rdy_n), .parallel_mode(pmo), .wide_mode(wmo),
      .reg_req(rr), .sdram_req(sr), .tgt_write(tw), .tgt_waddr(wa), .tgt_mask(mk),
      .tgt_wdata(wdo), .tgt_ack(ack), .tgt_rdata(rd));
   ahpp_tgt_model tgt_u (.sys_clk(sys_clk), .req(rr | sr), .sdram(sr), .tgt_write(tw),
      .tgt_waddr(wa),
      .tgt_mask(mk), .tgt_wdata(wdo), .dly(dly), .tgt_ack(ack), .tgt_rdata(rd));
   task automatic end_of_test;
      if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic boot(input logic p, input logic w);
      @(negedge sys_clk);
      rst_b = 1'h0;
      pm = p;
      wd = w;
      repeat (12) @(negedge sys_clk);
      // Clock enable low right after release: straps must not be caught yet
      ce = 1'h0;
      rst_b = 1'h1;
      repeat (3) @(negedge sys_clk);
      chk(32'({wmo, pmo}), 32'h0);
      ce = 1'h1;
      repeat (2) @(negedge sys_clk);
      chk(32'({wmo, pmo}), 32'({w, p}));
   endtask : boot
   // one item per select, released after ready
   task automatic acc(input logic w, input logic [24:1] a, input logic [3:0] b,
      input logic [31:0] d, output logic [31:0] r);
      cs_n = 1'h0;
      rw_n = ~w;
      ad = a;
      be = b;
      din = d;
      repeat (40) if (rdy_n !== 1'h0) @(negedge sys_clk);
      @(negedge sys_clk);
      chk(32'(rdy_n), 32'(!pm));
      chk(32'(oe_n), 32'(w | !pm));
      r = dout;
      cs_n = 1'h1;
      rw_n = 1'h1;
      be = 4'hF;
      din = ~d;
      repeat (40) if (rdy_n !== 1'h1) @(negedge sys_clk);
      @(negedge sys_clk);
   endtask : acc
   task automatic t_off;
      boot(1'h0, 1'h1);
      acc(1'h1, 24'h800000, 4'h0, 32'h12345678, q);
   endtask : t_off
   task automatic t_wide;
      boot(1'h1, 1'h1);
      dly = 4'h6;
      acc(1'h1, 24'h800004, 4'h0, 32'hAABBCCDD, q);
      acc(1'h1, 24'h800005, 4'hD, 32'h11223344, q);
      acc(1'h1, 24'h800004, 4'h5, 32'h99999999, q);
      acc(1'h0, 24'h800004, 4'hF, 32'h0, q);
      chk(q, 32'hAABB33DD);
      acc(1'h1, 24'h000004, 4'h0, 32'h01020304, q);
      acc(1'h1, 24'h000004, 4'h3, 32'h99999999, q);
      acc(1'h0, 24'h000004, 4'hF, 32'h0, q);
      chk(q, 32'h01020304);
      acc(1'h0, 24'h000005, 4'hF, 32'h0, q);
      chk(q, 32'h01020304);
      acc(1'h0, 24'h800005, 4'hF, 32'h0, q);
      chk(q, 32'hAABB33DD);
   endtask : t_wide
   task automatic t_narrow;
      boot(1'h1, 1'h0);
      dly = 4'h0;
      acc(1'h1, 24'h800000, 4'hC, 32'hFFFF5566, q);
      acc(1'h1, 24'h800001, 4'hC, 32'h00007788, q);
      acc(1'h1, 24'h800001, 4'hE, 32'h000011AB, q);
      acc(1'h0, 24'h800000, 4'hF, 32'h0, q);
      chk(q, 32'h00005566);
      acc(1'h0, 24'h800001, 4'hF, 32'h0, q);
      chk(q, 32'h000077AB);
   endtask : t_narrow
   // Cut a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         end_of_test();
      end
   end
   // Main sequence
   initial begin
      t_off();
      t_wide();
      t_narrow();
      end_of_test();
   end
endmodule : ahpp_port_tb
`default_nettype wire

// file: tb/ahpp_tgt_model.sv
// Target stand-in: small word store with adjustable acknowledge delay
`timescale 1ns/1ps
`default_nettype none
module ahpp_tgt_model (
   input wire logic sys_clk,
   input wire logic req,
   input wire logic sdram,
   input wire logic tgt_write,
   input wire logic [22:0] tgt_waddr,
   input wire logic [3:0] tgt_mask,
   input wire logic [31:0] tgt_wdata,
   input wire logic [3:0] dly,
   output logic tgt_ack = 1'h0,
   output logic [31:0] tgt_rdata = 32'h0
);
   // separate stores for register and SDRAM targets
   logic [31:0] mem [8];
   logic [3:0] n = 4'h0;
   // acknowledge after delay; data churns when not acknowledging
   always @(posedge sys_clk) begin
      tgt_ack <= 1'h0;
      tgt_rdata <= ~tgt_rdata;
      if (req && !tgt_ack && n < dly) begin
         n <= n + 4'h1;
      end else if (req && !tgt_ack) begin
         n <= 4'h0;
         tgt_ack <= 1'h1;
         tgt_rdata <= mem[{sdram, tgt_waddr[1:0]}];
         for (int i = 0; i < 4; i++) begin
            if (tgt_write && tgt_mask[i]) begin
               mem[{sdram, tgt_waddr[1:0]}][i*8+:8] <= tgt_wdata[i*8+:8];
            end
         end
      end
   end
endmodule : ahpp_tgt_model
`default_nettype wire
